// ==== include/pcc_params.svh ====
/*
 * constants of the pattern checker configuration and interrupt block.
 * assumes a 32-bit apb bus; register index times four gives the byte address.
 */
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------------------------------
`define PCC_IDX_GEN_CFG 14'h1242
`define PCC_IDX_CFG 14'h1243
`define PCC_IDX_ERR_STAT 14'h1244
`define PCC_IDX_ERR_EN 14'h1245
`define PCC_IDX_OVH_STAT 14'h1246
`define PCC_IDX_OVH_EN 14'h1247
`define PCC_IDX_LOCK_STAT 14'h1249
`define PCC_IDX_LOCK_EN 14'h124A
`define PCC_IDX_LOCK_NOW 14'h124B

// ----------------------------------------------------------------
// field positions, masks and reset values
// ----------------------------------------------------------------
`define PCC_SLOTS 12
`define PCC_BIT_SLAVE 15
`define PCC_BIT_FULL 14
`define PCC_POS_CHAIN 8
`define PCC_MASK_CFG 16'hC74F
`define PCC_MASK_GEN_CFG 16'hC000
`define PCC_RESET_REG 16'h0000
`define PCC_RESET_SLOTS 12'h000

`endif

// ==== include/pcc_pkg.sv ====
/*
 * types of the pattern checker configuration and interrupt block.
 * assumes pcc_params.svh for the slot count.
 */
`include "pcc_params.svh"
package pcc_pkg;

	// chain width codes
	typedef enum logic [2:0] {
		PCC_CHAIN_OFF = 3'h0,
		PCC_CHAIN_TWO = 3'h1,
		PCC_CHAIN_THREE = 3'h2,
		PCC_CHAIN_FOUR = 3'h3
	} pcc_chain_t;

	// per-slot inputs from the pattern engine
	typedef struct packed {
		logic [`PCC_SLOTS-1:0] in_sync;
		logic [`PCC_SLOTS-1:0] byte_mismatch;
		logic [`PCC_SLOTS-1:0] cmp_valid;
		logic [`PCC_SLOTS-1:0] cmp_mismatch;
	} pcc_slot_evt_t;

	// decoded payload layout toward the pattern engine
	typedef struct packed {
		logic tx_slave;
		logic rx_slave;
		logic rx_full;
		logic [`PCC_SLOTS-1:0] rx_slot_triple;
		logic [2:0] chain_count;
		logic chain_invalid;
	} pcc_payload_t;

endpackage : pcc_pkg

// ==== hw/pcc_checker_cfg.sv ====
/*
 * apb register file, payload decode and per-slot interrupt flags of the
 * pattern checker. assumes slot events come from logic on core_clk.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "pcc_params.svh"
module pcc_checker_cfg (
	input wire logic core_clk, // 20 MHz clock
	input wire logic reset_n, // synchronous reset
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [15:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error
	input wire logic block_select_a, // block select, high to enable
	input wire logic block_select_b, // block select, low to enable
	input wire pcc_pkg::pcc_slot_evt_t slot_evt, // per-slot engine events
	output pcc_pkg::pcc_payload_t payload, // decoded payload layout
	output logic irq_out // interrupt, active high
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [15:0] gen_cfg;
	logic [15:0] cfg;
	logic [11:0] err_mask, ovh_mask, lock_mask;
	logic [11:0] err_flag, ovh_flag, lock_flag;
	logic [11:0] last_cmp, sync_q;
	logic [15:0] next_gen_cfg, next_cfg;
	logic [11:0] next_err_mask, next_ovh_mask, next_lock_mask;
	logic [11:0] next_err_flag, next_ovh_flag, next_lock_flag;
	logic [11:0] next_last_cmp, next_sync_q;
	logic [31:0] next_prdata;
	logic next_pslverr;
	pcc_pkg::pcc_payload_t next_payload;
	logic next_irq;

	logic [13:0] idx;
	logic hit, mapped, setup, wr_take, rd_take;
	logic [11:0] ev_err, ev_ovh, ev_lock;
	logic [11:0] clr_err, clr_ovh, clr_lock;
	logic [11:0] triple_map;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// zero-wait slave: data is latched at setup, answered in access
	assign pready = 1'b1;
	assign idx = paddr[15:2];
	assign hit = block_select_a && !block_select_b;
	assign setup = psel && !penable;
	assign wr_take = psel && penable && pwrite && hit;
	assign rd_take = psel && penable && !pwrite && hit;

	// address match of every mapped register
	always_comb begin
		unique case (idx)
			`PCC_IDX_GEN_CFG, `PCC_IDX_CFG, `PCC_IDX_ERR_STAT, `PCC_IDX_ERR_EN,
			`PCC_IDX_OVH_STAT, `PCC_IDX_OVH_EN, `PCC_IDX_LOCK_STAT,
			`PCC_IDX_LOCK_EN, `PCC_IDX_LOCK_NOW: mapped = hit;
			default: mapped = 1'b0;
		endcase
	end

	// read data and error, captured in the setup cycle
	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup) begin
			next_prdata = 32'h0000_0000;
			next_pslverr = !mapped;
			if (mapped && !pwrite) begin
				unique case (idx)
					`PCC_IDX_GEN_CFG: next_prdata[15:0] = gen_cfg;
					`PCC_IDX_CFG: next_prdata[15:0] = cfg;
					`PCC_IDX_ERR_STAT: next_prdata[11:0] = err_flag;
					`PCC_IDX_ERR_EN: next_prdata[11:0] = err_mask;
					`PCC_IDX_OVH_STAT: next_prdata[11:0] = ovh_flag;
					`PCC_IDX_OVH_EN: next_prdata[11:0] = ovh_mask;
					`PCC_IDX_LOCK_STAT: next_prdata[11:0] = lock_flag;
					`PCC_IDX_LOCK_EN: next_prdata[11:0] = lock_mask;
					`PCC_IDX_LOCK_NOW: next_prdata[11:0] = slot_evt.in_sync;
					default: next_prdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	// writes land at the access edge; unused bits stay zero
	always_comb begin
		next_gen_cfg = gen_cfg;
		next_cfg = cfg;
		next_err_mask = err_mask;
		next_ovh_mask = ovh_mask;
		next_lock_mask = lock_mask;
		if (wr_take) begin
			unique case (idx)
				`PCC_IDX_GEN_CFG: next_gen_cfg = pwdata[15:0] & `PCC_MASK_GEN_CFG;
				`PCC_IDX_CFG: next_cfg = pwdata[15:0] & `PCC_MASK_CFG;
				`PCC_IDX_ERR_EN: next_err_mask = pwdata[11:0];
				`PCC_IDX_OVH_EN: next_ovh_mask = pwdata[11:0];
				`PCC_IDX_LOCK_EN: next_lock_mask = pwdata[11:0];
				default: next_gen_cfg = gen_cfg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// slot events and sticky flags
	// ----------------------------------------------------------------
	assign ev_err = slot_evt.in_sync & slot_evt.byte_mismatch;
	assign ev_ovh = slot_evt.in_sync & slot_evt.cmp_valid & (slot_evt.cmp_mismatch ^ last_cmp);
	assign ev_lock = slot_evt.in_sync ^ sync_q;
	// clear only what the read reported, so a later event survives
	assign clr_err = (rd_take && idx == `PCC_IDX_ERR_STAT) ? prdata[11:0] : `PCC_RESET_SLOTS;
	assign clr_ovh = (rd_take && idx == `PCC_IDX_OVH_STAT) ? prdata[11:0] : `PCC_RESET_SLOTS;
	assign clr_lock = (rd_take && idx == `PCC_IDX_LOCK_STAT) ? prdata[11:0] : `PCC_RESET_SLOTS;

	// flags set independent of masks, set wins over clear
	always_comb begin
		next_err_flag = (err_flag & ~clr_err) | ev_err;
		next_ovh_flag = (ovh_flag & ~clr_ovh) | ev_ovh;
		next_lock_flag = (lock_flag & ~clr_lock) | ev_lock;
		next_last_cmp = (last_cmp & ~slot_evt.cmp_valid) | (slot_evt.cmp_mismatch & slot_evt.cmp_valid);
		next_sync_q = slot_evt.in_sync;
	end

	// ----------------------------------------------------------------
	// payload decode and interrupt
	// ----------------------------------------------------------------
	// slot k of each triple follows triple bit k mod 4
	genvar g;
	generate
		for (g = 0; g < `PCC_SLOTS; g++) begin : g_slot
			assign triple_map[g] = cfg[g % 4];
		end
	endgenerate

	// layout and interrupt terms
	always_comb begin
		next_payload.tx_slave = gen_cfg[`PCC_BIT_SLAVE];
		next_payload.rx_slave = cfg[`PCC_BIT_SLAVE];
		next_payload.rx_full = cfg[`PCC_BIT_FULL];
		next_payload.rx_slot_triple = cfg[`PCC_BIT_FULL] ? `PCC_RESET_SLOTS : triple_map;
		next_payload.chain_invalid = 1'b0;
		unique case (cfg[`PCC_POS_CHAIN +: 3])
			pcc_pkg::PCC_CHAIN_OFF: next_payload.chain_count = 3'h1;
			pcc_pkg::PCC_CHAIN_TWO: next_payload.chain_count = 3'h2;
			pcc_pkg::PCC_CHAIN_THREE: next_payload.chain_count = 3'h3;
			pcc_pkg::PCC_CHAIN_FOUR: next_payload.chain_count = 3'h4;
			default: begin
				next_payload.chain_count = 3'h0;
				next_payload.chain_invalid = 1'b1;
			end
		endcase
		next_irq = |(err_flag & err_mask) | |(ovh_flag & ovh_mask) | |(lock_flag & lock_mask);
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			gen_cfg <= `PCC_RESET_REG;
			cfg <= `PCC_RESET_REG;
			err_mask <= `PCC_RESET_SLOTS;
			ovh_mask <= `PCC_RESET_SLOTS;
			lock_mask <= `PCC_RESET_SLOTS;
			err_flag <= `PCC_RESET_SLOTS;
			ovh_flag <= `PCC_RESET_SLOTS;
			lock_flag <= `PCC_RESET_SLOTS;
			last_cmp <= `PCC_RESET_SLOTS;
			sync_q <= `PCC_RESET_SLOTS;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			payload <= '0;
			irq_out <= 1'b0;
		end else begin
			gen_cfg <= next_gen_cfg;
			cfg <= next_cfg;
			err_mask <= next_err_mask;
			ovh_mask <= next_ovh_mask;
			lock_mask <= next_lock_mask;
			err_flag <= next_err_flag;
			ovh_flag <= next_ovh_flag;
			lock_flag <= next_lock_flag;
			last_cmp <= next_last_cmp;
			sync_q <= next_sync_q;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			payload <= next_payload;
			irq_out <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_err_set_sticky: assert property (
		(|ev_err) |=> ((err_flag & $past(ev_err)) == $past(ev_err)))
		else $error("byte error event not flagged");

	chk_err_read_clear: assert property (
		(rd_take && idx == `PCC_IDX_ERR_STAT && ev_err == 12'h000)
			|=> ((err_flag & $past(prdata[11:0])) == 12'h000))
		else $error("byte error flag not cleared by read");

	chk_ovh_change_set: assert property (
		(slot_evt.cmp_valid[0] && slot_evt.in_sync[0] && (slot_evt.cmp_mismatch[0] != last_cmp[0]))
			|=> ovh_flag[0])
		else $error("overhead compare change not flagged");

	chk_ovh_repeat_hold: assert property (
		(slot_evt.cmp_valid[0] && slot_evt.cmp_mismatch[0] && last_cmp[0] && !ovh_flag[0])
			|=> !ovh_flag[0])
		else $error("repeated mismatch changed the flag");

	chk_lock_change_set: assert property (
		(slot_evt.in_sync[0] != sync_q[0]) |=> lock_flag[0])
		else $error("lock change not flagged");

	chk_irq_masked_or: assert property (
		((lock_flag & lock_mask) != 12'h000) |=> irq_out)
		else $error("masked lock flag did not raise interrupt");

	chk_irq_quiet_masks: assert property (
		(err_mask == 12'h000 && ovh_mask == 12'h000 && lock_mask == 12'h000) [*2] |-> !irq_out)
		else $error("interrupt with every mask cleared");

	chk_triple_group: assert property (
		1 |=> (payload.rx_slot_triple[8] == ($past(cfg[0]) && !$past(cfg[`PCC_BIT_FULL]))))
		else $error("triple grouping of slot nine wrong");

	chk_chain_code: assert property (
		(cfg[10:8] == 3'h3) |=> (payload.chain_count == 3'h4 && !payload.chain_invalid))
		else $error("chain of four decoded wrong");

	chk_slave_follow: assert property (
		1 |=> (payload.rx_slave == $past(cfg[`PCC_BIT_SLAVE])))
		else $error("slave payload does not follow its bit");

	chk_decode_gate: assert property (
		(setup && !block_select_a) |=> (pslverr && prdata == 32'h0000_0000))
		else $error("access decoded while deselected");

	// read clears of the other two status registers
	chk_ovh_read_clear: assert property (
		(rd_take && idx == `PCC_IDX_OVH_STAT && ev_ovh == 12'h000)
			|=> ((ovh_flag & $past(prdata[11:0])) == 12'h000))
		else $error("overhead compare flag not cleared by read");

	chk_lock_read_clear: assert property (
		(rd_take && idx == `PCC_IDX_LOCK_STAT && ev_lock == 12'h000)
			|=> ((lock_flag & $past(prdata[11:0])) == 12'h000))
		else $error("lock change flag not cleared by read");

	// an unlocked slot never collects a byte error
	chk_err_needs_lock: assert property (
		(!slot_evt.in_sync[1] && !err_flag[1]) |=> !err_flag[1])
		else $error("byte error flagged on unlocked slot");

	// each mask routes its own source to the interrupt
	chk_err_irq_route: assert property (
		(err_flag[0] && err_mask[0]) |=> irq_out)
		else $error("masked byte error did not raise interrupt");

	chk_ovh_irq_route: assert property (
		((ovh_flag & ovh_mask) != 12'h000) |=> irq_out)
		else $error("masked overhead flag did not raise interrupt");

	// payload layout follows the configuration one cycle later
	chk_full_follow: assert property (
		1 |=> (payload.rx_full == $past(cfg[`PCC_BIT_FULL])))
		else $error("full concatenation does not follow its bit");

	chk_chain_invalid: assert property (
		cfg[`PCC_POS_CHAIN + 2] |=> (payload.chain_invalid && payload.chain_count == 3'h0))
		else $error("invalid chain width not flagged");

	chk_tx_slave_follow: assert property (
		1 |=> (payload.tx_slave == $past(gen_cfg[`PCC_BIT_SLAVE])))
		else $error("generator slave payload does not follow its bit");

	// refused writes leave the configuration untouched
	chk_write_gate: assert property (
		(psel && penable && pwrite && !hit) |=> (cfg == $past(cfg)))
		else $error("configuration written while deselected");

	// main scenarios
	cov_err_irq: cover property (err_flag[0] && err_mask[0] ##1 irq_out);
	cov_read_clear: cover property (rd_take && idx == `PCC_IDX_LOCK_STAT && prdata[11:0] != 12'h000);
	cov_full_concat: cover property (payload.rx_full && payload.chain_count == 3'h4);
	cov_chain_bad: cover property (payload.chain_invalid && payload.rx_full);

endmodule : pcc_checker_cfg

// ==== test/pcc_host.sv ====
/*
 * bus host model: runs one apb transfer at a time.
 * assumes pready comes within 16 clocks; hang rises if it never does.
 */
`timescale 1ns/100ps
module pcc_host (
	input wire logic core_clk, // bus clock
	input wire logic pready, // slave ready
	output logic psel, // select
	output logic penable, // access phase
	output logic pwrite, // direction
	output logic [15:0] paddr, // byte address
	output logic [31:0] pwdata, // write data
	output logic hang // ready never came
);
	// idle bus at time zero
	initial begin
		{psel, penable, pwrite, paddr, pwdata, hang} = '0;
	end
	// setup cycle, then access held until pready is seen high
	task xfer(input logic wr, input logic [13:0] idx, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		hang <= (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : pcc_host

// ==== test/prbs_checker_config_irq_bench.sv ====
/*
 * self-checking bench of the checker configuration and interrupt block.
 * assumes pcc_host as bus master and a 20 MHz core clock.
 */
`timescale 1ns/100ps
`include "pcc_params.svh"
module prbs_checker_config_irq_bench;
	logic core_clk = 1'b0;
	logic reset_n, psel, penable, pwrite, pready, pslverr, irq_out, hang, sel_a, sel_b;
	logic [15:0] paddr, c;
	logic [31:0] pwdata, prdata, r;
	pcc_pkg::pcc_slot_evt_t ev;
	pcc_pkg::pcc_payload_t payload;
	logic [32:0] exp_q[$];
	logic [13:0] tab[9];
	int num_errors, total_checks;
	// ----------------------------------------------------------------
	// design and host
	// ----------------------------------------------------------------
	pcc_checker_cfg dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .block_select_a(sel_a), .block_select_b(sel_b), .slot_evt(ev),
		.payload(payload), .irq_out(irq_out));
	pcc_host host (.core_clk(core_clk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hang(hang));
	// free running clock
	always #25 core_clk = ~core_clk;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	task cmp(input logic [32:0] e, input logic [32:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp
	task chk_irq(input logic e);
		repeat (2) @(posedge core_clk);
		#1;
		cmp({32'h0000_0000, e}, {32'h0000_0000, irq_out});
	endtask : chk_irq
	task chk_pay(input logic [15:0] cf);
		pcc_pkg::pcc_payload_t p;
		p.tx_slave = 1'b1;
		p.rx_slave = cf[15];
		p.rx_full = cf[14];
		p.rx_slot_triple = cf[14] ? 12'h000 : {3{cf[3:0]}};
		p.chain_invalid = cf[10];
		p.chain_count = cf[10] ? 3'h0 : cf[10:8] + 3'h1;
		#1;
		cmp({14'h0000, p}, {14'h0000, payload});
	endtask : chk_pay
	// each completed read takes the oldest note off the queue
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) cmp(33'h0_0000_0000, 33'h1_ffff_ffff);
			else cmp(exp_q.pop_front(), {pslverr, prdata});
		end
		if (hang === 1'b1) begin
			num_errors++;
			summarize();
		end
	end
	// ----------------------------------------------------------------
	// stimulus helpers
	// ----------------------------------------------------------------
	task rd(input logic [13:0] i, input logic [15:0] d, input logic er);
		exp_q.push_back({er, 16'h0000, d});
		host.xfer(1'b0, i, 16'h0000);
	endtask : rd
	task wr(input logic [13:0] i, input logic [15:0] d);
		host.xfer(1'b1, i, d);
	endtask : wr
	task pulse(input logic [11:0] bm, input logic [11:0] cv, input logic [11:0] cm);
		@(posedge core_clk);
		ev.byte_mismatch <= bm;
		ev.cmp_valid <= cv;
		ev.cmp_mismatch <= cm;
		@(posedge core_clk);
		ev.byte_mismatch <= 12'h000;
		ev.cmp_valid <= 12'h000;
	endtask : pulse
	task summarize;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		sel_a = 1'b1;
		sel_b = 1'b0;
		ev = '0;
		num_errors = 0;
		total_checks = 0;
		tab = '{14'h1242, 14'h1243, 14'h1244, 14'h1245, 14'h1246, 14'h1247, 14'h1249, 14'h124A, 14'h124B};
		r = $urandom(32'h6603_022d);
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		foreach (tab[i]) rd(tab[i], 16'h0000, 1'b0);
		wr(`PCC_IDX_GEN_CFG, 16'hC000);
		rd(`PCC_IDX_GEN_CFG, 16'hC000, 1'b0);
		// full concat with every width code, then random triple groupings
		for (int k = 0; k < 12; k++) begin
			r = $urandom;
			c = (k < 8) ? {r[0], 1'b1, 3'h0, 3'(k), 8'h00} : {12'h000, r[3:0]};
			wr(`PCC_IDX_CFG, c);
			rd(`PCC_IDX_CFG, c, 1'b0);
			chk_pay(c);
		end
		// refused accesses leave the configuration alone
		rd(14'h1248, 16'h0000, 1'b1);
		sel_a <= 1'b0;
		rd(`PCC_IDX_CFG, 16'h0000, 1'b1);
		sel_a <= 1'b1;
		sel_b <= 1'b1;
		wr(`PCC_IDX_CFG, 16'h4000);
		sel_b <= 1'b0;
		rd(`PCC_IDX_CFG, c, 1'b0);
		// lock changes with all masks clear
		ev.in_sync <= 12'h0A5;
		chk_irq(1'b0);
		rd(`PCC_IDX_LOCK_STAT, 16'h00A5, 1'b0);
		rd(`PCC_IDX_LOCK_STAT, 16'h0000, 1'b0);
		rd(`PCC_IDX_LOCK_NOW, 16'h00A5, 1'b0);
		// byte errors only on locked slots
		pulse(12'hFFF, 12'h000, 12'h000);
		chk_irq(1'b0);
		wr(`PCC_IDX_ERR_EN, 16'h0001);
		chk_irq(1'b1);
		rd(`PCC_IDX_ERR_STAT, 16'h00A5, 1'b0);
		chk_irq(1'b0);
		// overhead compare: change, repeat, change back
		pulse(12'h000, 12'hFFF, 12'hFFF);
		wr(`PCC_IDX_OVH_EN, 16'h0004);
		chk_irq(1'b1);
		rd(`PCC_IDX_OVH_STAT, 16'h00A5, 1'b0);
		pulse(12'h000, 12'hFFF, 12'hFFF);
		rd(`PCC_IDX_OVH_STAT, 16'h0000, 1'b0);
		pulse(12'h000, 12'hFFF, 12'h000);
		rd(`PCC_IDX_OVH_STAT, 16'h00A5, 1'b0);
		chk_irq(1'b0);
		// slot one drops out of lock
		wr(`PCC_IDX_LOCK_EN, 16'h0001);
		ev.in_sync <= 12'h0A4;
		chk_irq(1'b1);
		rd(`PCC_IDX_LOCK_STAT, 16'h0001, 1'b0);
		chk_irq(1'b0);
		cmp(33'h0_0000_0000, {1'b0, 32'(exp_q.size())});
		summarize();
	end
endmodule : prbs_checker_config_irq_bench
